// ===== hw/vc_resource_regs.sv
// channel resource control and status register bank on apb
// Summary of operation
// - class map, bit0 fixed, resets ones
// - writing one requests table load
// - load bit always reads zero
// - load only acts on upstream port
// - load only for table based scheme
// - three bit scheme select, reset zero
// - channel identifier reads zero, read only
// - channel enable reads one, read only
// - table write sets stale flag
// - stale clears after requested load completes
// - stale reads zero on downstream ports
// - negotiation pending mirrors flow control init
// - capability 0x3 upstream, 0x1 downstream
// - invalid phase port skipped without delay
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module vc_resource_regs #(
    parameter logic [15:0] VALID_PORTS = vc_resource_pkg::VALID_PORT_MASK
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic isUpstream,
    input wire logic [3:0] selfPortId,
    input wire logic tableWrite,
    input wire logic loadDone,
    input wire logic fcInitPending,
    input wire logic [3:0] phasePortId,
    output logic phaseSkip,
    output logic loadReq,
    output logic [7:0] classMap,
    output logic [2:0] arbSchemeSelect,
    output logic [7:0] arbCapability
);
    reg_access_if acc ();

    logic [7:0] classMap_q;
    logic [7:0] classMap_d;
    logic [2:0] scheme_q;
    logic [2:0] scheme_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic negotiation_q;
    logic negotiation_d;
    logic [7:0] capability;
    logic ctrlWrite;
    logic loadWrite;
    logic loadAllowed;
    logic stale;
    logic [31:0] ctrlView;
    logic [31:0] statusView;

    // ************************************************************
    // bus decode
    // ************************************************************
    apb_access_decode u_apb_access_decode (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .acc(acc)
    );

    // no wait states; unmapped addresses answer with an error
    always_comb begin
        pready = 1'b1;
        pslverr = psel & penable & ~acc.mapped;
    end

    // ************************************************************
    // capability and scheme qualification
    // ************************************************************
    always_comb begin
        capability = isUpstream ? vc_resource_pkg::CAP_UPSTREAM
                                : vc_resource_pkg::CAP_DOWNSTREAM;
        // the scheme written alongside the load bit decides, not the old one
        // fixed round robin uses no table, so only a set higher bit qualifies
        loadAllowed = capability[scheme_d] &
                      (scheme_d != vc_resource_pkg::SCHEME_FIXED_RR);
    end

    // ************************************************************
    // control register writes
    // ************************************************************
    always_comb begin
        ctrlWrite = acc.wrStrobe & (acc.addr == vc_resource_pkg::CONTROL_OFFSET);
        loadWrite = ctrlWrite & acc.wdata[vc_resource_pkg::LOAD_BIT];
        classMap_d = classMap_q;
        scheme_d = scheme_q;
        if (ctrlWrite) begin
            classMap_d = (acc.wdata[vc_resource_pkg::MAP_LSB +: vc_resource_pkg::MAP_W] &
                          ~vc_resource_pkg::MAP_RO_MASK) |
                         vc_resource_pkg::MAP_RO_MASK;
            // software is trusted to pick a supported scheme
            scheme_d = acc.wdata[vc_resource_pkg::SCHEME_LSB +: vc_resource_pkg::SCHEME_W];
        end
    end

    // ************************************************************
    // table coherency tracking
    // ************************************************************
    arb_table_tracker u_arb_table_tracker (
        .clk(clk),
        .rst_n(rst_n),
        .isUpstream(isUpstream),
        .loadWrite(loadWrite),
        .loadAllowed(loadAllowed),
        .tableWrite(tableWrite),
        .loadDone(loadDone),
        .loadReq(loadReq),
        .stale(stale)
    );

    // ************************************************************
    // read views
    // ************************************************************
    always_comb begin
        ctrlView = vc_resource_pkg::READ_ZERO;
        ctrlView[vc_resource_pkg::MAP_LSB +: vc_resource_pkg::MAP_W] = classMap_q;
        ctrlView[vc_resource_pkg::LOAD_BIT] = 1'b0;
        ctrlView[vc_resource_pkg::SCHEME_LSB +: vc_resource_pkg::SCHEME_W] = scheme_q;
        ctrlView[vc_resource_pkg::CHANNEL_ID_LSB +: vc_resource_pkg::CHANNEL_ID_W] =
            vc_resource_pkg::CHANNEL_ID_VALUE;
        ctrlView[vc_resource_pkg::ENABLE_BIT] = vc_resource_pkg::ENABLE_VALUE;
        statusView = vc_resource_pkg::READ_ZERO;
        statusView[vc_resource_pkg::STALE_BIT] = stale;
        statusView[vc_resource_pkg::NEGOTIATION_BIT] = negotiation_q;
    end

    // read data is captured in the setup phase and held through access
    always_comb begin
        prdata_d = prdata_q;
        negotiation_d = fcInitPending;
        if (acc.rdSetup) begin
            if (acc.addr == vc_resource_pkg::CONTROL_OFFSET) begin
                prdata_d = ctrlView;
            end else if (acc.addr == vc_resource_pkg::STATUS_OFFSET) begin
                prdata_d = statusView;
            end else begin
                prdata_d = vc_resource_pkg::READ_ZERO;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            classMap_q <= vc_resource_pkg::MAP_RESET;
            scheme_q <= vc_resource_pkg::SCHEME_RESET;
            prdata_q <= vc_resource_pkg::READ_ZERO;
            negotiation_q <= 1'b0;
        end else begin
            classMap_q <= classMap_d;
            scheme_q <= scheme_d;
            prdata_q <= prdata_d;
            negotiation_q <= negotiation_d;
        end
    end

    // ************************************************************
    // phase entry screening
    // ************************************************************
    // combinational so the arbiter can step past the entry in the same cycle
    always_comb begin
        phaseSkip = ~VALID_PORTS[phasePortId] | (phasePortId == selfPortId);
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata = prdata_q;
    assign classMap = classMap_q;
    assign arbSchemeSelect = scheme_q;
    assign arbCapability = capability;
endmodule : vc_resource_regs
`default_nettype wire

// ===== hw/vc_resource_pkg.sv
// constants for the channel resource control and status registers
package vc_resource_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [11:0] CONTROL_OFFSET = 12'h214;
    localparam logic [11:0] STATUS_OFFSET = 12'h218;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int MAP_LSB = 0;
    localparam int MAP_W = 8;
    localparam int LOAD_BIT = 16;
    localparam int SCHEME_LSB = 17;
    localparam int SCHEME_W = 3;
    localparam int CHANNEL_ID_LSB = 24;
    localparam int CHANNEL_ID_W = 3;
    localparam int ENABLE_BIT = 31;

    // ************************************************************
    // status register fields
    // ************************************************************
    localparam int STALE_BIT = 0;
    localparam int NEGOTIATION_BIT = 1;

    // ************************************************************
    // reset and fixed values
    // ************************************************************
    localparam logic [7:0] MAP_RESET = 8'hff;
    localparam logic [7:0] MAP_RO_MASK = 8'h01;
    localparam logic [2:0] SCHEME_RESET = 3'h0;
    localparam logic [2:0] CHANNEL_ID_VALUE = 3'h0;
    localparam logic ENABLE_VALUE = 1'b1;
    localparam logic [7:0] CAP_UPSTREAM = 8'h03;
    localparam logic [7:0] CAP_DOWNSTREAM = 8'h01;
    localparam logic [2:0] SCHEME_FIXED_RR = 3'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ************************************************************
    // arbitration table phase entries
    // ************************************************************
    localparam int PORT_ID_W = 4;
    localparam logic [15:0] VALID_PORT_MASK = 16'h003d;

endpackage : vc_resource_pkg

// ===== hw/reg_access_if.sv
// carrier between the bus decoder and the register bank
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
    logic wrStrobe;
    logic rdSetup;
    logic mapped;
    logic [11:0] addr;
    logic [31:0] wdata;

    modport decoder (
        output wrStrobe,
        output rdSetup,
        output mapped,
        output addr,
        output wdata
    );
    modport regs (
        input wrStrobe,
        input rdSetup,
        input mapped,
        input addr,
        input wdata
    );
endinterface : reg_access_if
`default_nettype wire

// ===== hw/apb_access_decode.sv
// apb phase decode into register strobes
`timescale 1ns/100ps
`default_nettype none
module apb_access_decode (
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    reg_access_if.decoder acc
);
    // ************************************************************
    // strobes
    // ************************************************************
    // zero wait states, so the access phase always completes
    always_comb begin
        acc.wrStrobe = psel & penable & pwrite;
        acc.rdSetup = psel & ~penable & ~pwrite;
        acc.addr = paddr;
        acc.wdata = pwdata;
        acc.mapped = (paddr == vc_resource_pkg::CONTROL_OFFSET) |
                     (paddr == vc_resource_pkg::STATUS_OFFSET);
    end
endmodule : apb_access_decode
`default_nettype wire

// ===== hw/arb_table_tracker.sv
// table coherency flag and load request pulse
`timescale 1ns/100ps
`default_nettype none
module arb_table_tracker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic isUpstream,
    input wire logic loadWrite,
    input wire logic loadAllowed,
    input wire logic tableWrite,
    input wire logic loadDone,
    output logic loadReq,
    output logic stale
);
    logic stale_q;
    logic stale_d;
    logic pending_q;
    logic pending_d;
    logic loadReq_q;
    logic loadReq_d;
    logic issue;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        issue = loadWrite & loadAllowed & isUpstream;
        loadReq_d = issue;
        pending_d = pending_q;
        if (issue) begin
            pending_d = 1'b1;
        end else if (loadDone) begin
            pending_d = 1'b0;
        end
        stale_d = stale_q;
        if (loadDone & pending_q) begin
            stale_d = 1'b0;
        end
        // a table write in the same cycle as completion wins
        if (tableWrite) begin
            stale_d = 1'b1;
        end
        if (!isUpstream) begin
            stale_d = 1'b0;
            pending_d = 1'b0;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stale_q <= 1'b0;
            pending_q <= 1'b0;
            loadReq_q <= 1'b0;
        end else begin
            stale_q <= stale_d;
            pending_q <= pending_d;
            loadReq_q <= loadReq_d;
        end
    end

    assign loadReq = loadReq_q;
    assign stale = stale_q & isUpstream;
endmodule : arb_table_tracker
`default_nettype wire

// ===== verif/vc_resource_ctl_status_properties.sv
// checker for the channel resource register bank
`timescale 1ns/100ps
`default_nettype none
module vc_resource_ctl_status_properties #(
    parameter logic [15:0] VALID_PORTS = 16'h003d
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic isUpstream,
    input wire logic [3:0] selfPortId,
    input wire logic [3:0] phasePortId,
    input wire logic phaseSkip,
    input wire logic loadReq,
    input wire logic [7:0] classMap,
    input wire logic [2:0] arbSchemeSelect,
    input wire logic [7:0] arbCapability
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence access;
        psel && penable;
    endsequence
    sequence ctrlWr;
        access ##0 pwrite && paddr == 12'h214;
    endsequence
    mapBitZero_a: assert property (classMap[0] == 1'b1)
        else $error("map bit0 low");
    ctrlStore_a: assert property (ctrlWr |=> classMap == ($past(pwdata[7:0]) | 8'h01)
        && arbSchemeSelect == $past(pwdata[19:17])) else $error("ctrl not stored");
    idleHold_a: assert property (!psel |=> $stable(classMap) && $stable(arbSchemeSelect))
        else $error("ctrl changed idle");
    loadCause_a: assert property (loadReq |-> $past(psel && penable && pwrite
        && paddr == 12'h214 && pwdata[16] && pwdata[19:17] == 3'h1 && isUpstream))
        else $error("stray load");
    loadPulse_a: assert property (loadReq |=> !loadReq)
        else $error("load pulse long");
    resetVals_a: assert property ($rose(rst_n) |-> classMap == 8'hff
        && arbSchemeSelect == 3'h0 && !loadReq) else $error("bad reset value");
    capValue_a: assert property (arbCapability == (isUpstream ? 8'h03 : 8'h01))
        else $error("capability wrong");
    phaseSkip_a: assert property (phaseSkip ==
        (!VALID_PORTS[phasePortId] || phasePortId == selfPortId)) else $error("skip wrong");
    addrError_a: assert property (access |-> pready &&
        pslverr == (paddr != 12'h214 && paddr != 12'h218)) else $error("error flag wrong");
endmodule : vc_resource_ctl_status_properties
bind vc_resource_regs vc_resource_ctl_status_properties #(.VALID_PORTS(VALID_PORTS)) u_props (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .isUpstream(isUpstream), .selfPortId(selfPortId), .phasePortId(phasePortId),
    .phaseSkip(phaseSkip), .loadReq(loadReq), .classMap(classMap),
    .arbSchemeSelect(arbSchemeSelect), .arbCapability(arbCapability));
`default_nettype wire

// ===== verif/vc_resource_ctl_status_tb.sv
// self-checking bench for the channel resource register bank
`timescale 1ns/100ps
`default_nettype none
module vc_resource_ctl_status_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, a;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic pready, pslverr, phaseSkip, loadReq, e;
    logic isUpstream = 1'b1, tableWrite = 1'b0, loadDone = 1'b0, fcInitPending = 1'b0;
    logic [3:0] selfPortId = 4'h0, phasePortId = 4'h0, s;
    logic [7:0] classMap, arbCapability;
    logic [2:0] arbSchemeSelect;
    int err_count = 0, checks = 0, pulses = 0, cycles = 0;
    vc_resource_regs u_vc_resource_regs (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .isUpstream(isUpstream),
        .selfPortId(selfPortId), .tableWrite(tableWrite), .loadDone(loadDone),
        .fcInitPending(fcInitPending), .phasePortId(phasePortId), .phaseSkip(phaseSkip),
        .loadReq(loadReq), .classMap(classMap), .arbSchemeSelect(arbSchemeSelect),
        .arbCapability(arbCapability));
    // ****
    // helpers
    // ****
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (loadReq === 1'b1) pulses++;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end
    task conclude();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task chk(input string n, input logic [31:0] sv, input logic [31:0] xv);
        checks++;
        if (sv !== xv) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, xv, sv);
        end
    endtask : chk
    // setup then access; held until pready is seen high
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] v);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task pulseTable();
        tableWrite <= 1'b1;
        @(posedge clk);
        tableWrite <= 1'b0;
    endtask : pulseTable
    function automatic logic [31:0] ctrlExp(input logic [31:0] v);
        return {1'b1, 7'h00, 4'h0, v[19:17], 1'b0, 8'h00, v[7:1], 1'b1};
    endfunction : ctrlExp
    // ****
    // tests
    // ****
    initial begin
        void'($urandom(32'h42e2));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h214, 32'h0);
        chk("ctrl reset", rd, 32'h8000_00ff);
        apb(1'b0, 12'h218, 32'h0);
        chk("status reset", rd, 32'h0);
        $display("reset test done");
        // scheme kept legal for the upstream capability; load bit off here
        for (int i = 0; i < 24; i++) begin
            d = $urandom() & 32'hfff2_ffff;
            if (i == 0) d = 32'h0;
            if (i == 1) d = 32'hfff2_ffff;
            apb(1'b1, 12'h214, d);
            apb(1'b0, 12'h214, 32'h0);
            chk("ctrl read", rd, ctrlExp(d));
            chk("map out", {24'h0, classMap}, {24'h0, d[7:1], 1'b1});
            chk("scheme out", {29'h0, arbSchemeSelect}, {29'h0, d[19:17]});
        end
        chk("no load", pulses, 0);
        $display("control test done");
        a = 12'($urandom()) | 12'h001;
        apb(1'b1, a, 32'hffff_ffff);
        apb(1'b1, 12'h218, 32'hffff_ffff);
        apb(1'b0, a, 32'h0);
        chk("unmapped err", {31'h0, e}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b0, 12'h218, 32'h0);
        chk("status ro", rd, 32'h0);
        apb(1'b0, 12'h214, 32'h0);
        chk("ctrl kept", rd, ctrlExp(d));
        $display("access test done");
        apb(1'b1, 12'h214, 32'h0002_00ff);
        pulseTable();
        apb(1'b0, 12'h218, 32'h0);
        chk("stale set", rd, 32'h1);
        apb(1'b1, 12'h214, 32'h0002_00ff);
        apb(1'b1, 12'h214, 32'h0003_00ff);
        #1 chk("load pulse", {31'h0, loadReq}, 32'h1);
        @(posedge clk);
        #1 chk("load end", {31'h0, loadReq}, 32'h0);
        apb(1'b0, 12'h214, 32'h0);
        chk("load reads 0", rd, 32'h8002_00ff);
        apb(1'b0, 12'h218, 32'h0);
        chk("stale held", rd, 32'h1);
        loadDone <= 1'b1;
        @(posedge clk);
        loadDone <= 1'b0;
        apb(1'b0, 12'h218, 32'h0);
        chk("stale clear", rd, 32'h0);
        pulseTable();
        apb(1'b1, 12'h214, 32'h0001_00ff);
        // a pulse would show one cycle after the write edge, so wait past it
        @(posedge clk);
        #1 chk("fixed no load", pulses, 1);
        fcInitPending <= 1'b1;
        apb(1'b0, 12'h218, 32'h0);
        chk("pending", rd, 32'h3);
        $display("load test done");
        isUpstream <= 1'b0;
        @(posedge clk);
        #1 chk("cap down", {24'h0, arbCapability}, 32'h1);
        pulseTable();
        apb(1'b1, 12'h214, 32'h0003_00ff);
        apb(1'b0, 12'h218, 32'h0);
        // negotiation still pending, stale forced low
        chk("down status", rd, 32'h2);
        chk("down no load", pulses, 1);
        isUpstream <= 1'b1;
        $display("downstream test done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            s = 4'($urandom());
            phasePortId <= 4'(i);
            selfPortId <= s;
            #1 chk("skip", {31'h0, phaseSkip},
                   {31'h0, !vc_resource_pkg::VALID_PORT_MASK[i] || 4'(i) == s});
        end
        $display("phase test done");
        conclude();
    end
endmodule : vc_resource_ctl_status_tb
`default_nettype wire
